//--- design/msr_pkg.sv
// Package of register offsets, field positions and carrier types for the sample readout.
package msr_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] MSR_ADDR_STATUS = 8'h1e;
   localparam logic [7:0] MSR_ADDR_TEMP_LO = 8'h20;
   localparam logic [7:0] MSR_ADDR_TEMP_HI = 8'h21;
   localparam logic [7:0] MSR_ADDR_PITCH_LO = 8'h22;
   localparam logic [7:0] MSR_ADDR_PITCH_HI = 8'h23;
   localparam logic [7:0] MSR_ADDR_ROLL_LO = 8'h24;
   localparam logic [7:0] MSR_ADDR_ROLL_HI = 8'h25;
   localparam logic [7:0] MSR_ADDR_YAW_LO = 8'h26;
   localparam logic [7:0] MSR_ADDR_YAW_HI = 8'h27;

   // ----------------------------------------
   // Status byte fields and reset values
   // ----------------------------------------
   localparam int MSR_BIT_ACCEL = 0;
   localparam int MSR_BIT_RATE = 1;
   localparam int MSR_BIT_TEMP = 2;
   localparam logic MSR_FLAG_RST = 1'b0;
   localparam logic [15:0] MSR_WORD_RST = 16'h0000;
   localparam logic [7:0] MSR_BYTE_ZERO = 8'h00;

   // ----------------------------------------
   // Sizes and word slots
   // ----------------------------------------
   localparam int MSR_N_KIND = 3;
   localparam int MSR_N_WORD = 4;
   localparam int MSR_WORD_W = 16;
   localparam int MSR_BYTE_W = 8;
   localparam int MSR_WORD_TEMP = 0;
   localparam int MSR_WORD_PITCH = 1;
   localparam int MSR_WORD_ROLL = 2;
   localparam int MSR_WORD_YAW = 3;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed
   {
      logic [15:0] yaw;
      logic [15:0] roll;
      logic [15:0] pitch;
   } msr_rate_set_t;

   typedef struct packed
   {
      logic       rd_en;
      logic [7:0] addr;
   } msr_rd_req_t;

endpackage

//--- design/msr_readout.sv
// Read-only register slice holding the newest temperature and angular-rate samples.
`timescale 1ns/100ps

module msr_readout
(
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 srst_i,
   // Sample datapath
   input  wire logic                 temp_valid_i,
   input  wire logic [15:0]          temp_word_i,
   input  wire logic                 rate_valid_i,
   input  wire msr_pkg::msr_rate_set_t rate_set_i,
   input  wire logic                 accel_valid_i,
   input  wire logic                 accel_read_i,
   // Host register read port
   input  wire msr_pkg::msr_rd_req_t rd_req_i,
   output logic [7:0]                rd_data_o,
   output logic                      rd_valid_o,
   // Flags for the wider device
   output logic [2:0]                sample_ready_o
);
   import msr_pkg::*;

   // ----------------------------------------
   // Build-time checks
   // ----------------------------------------
   // The status byte and the word slots are laid out from the package constants.
   // Flag positions outside the field, more flags than status bits, a word not two bytes wide and a yaw slot outside the table are refused here.
   generate
      if ((MSR_BIT_TEMP >= MSR_N_KIND) || (MSR_BIT_RATE >= MSR_N_KIND) || (MSR_BIT_ACCEL >= MSR_N_KIND))
      begin : g_bad_flag_pos
         $error("Flag position lies outside the flag field.");
      end
      if (MSR_N_KIND > MSR_BYTE_W)
      begin : g_bad_kind_count
         $error("More flags than bits in the status byte.");
      end
      if (MSR_WORD_W != 2 * MSR_BYTE_W)
      begin : g_bad_word_width
         $error("A result word must span exactly two bytes.");
      end
      if (MSR_WORD_YAW >= MSR_N_WORD)
      begin : g_bad_word_slot
         $error("Word slot lies outside the word table.");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [MSR_WORD_W-1:0] temp_ff;
   logic [MSR_WORD_W-1:0] nxt_temp;
   msr_rate_set_t rate_ff;
   msr_rate_set_t nxt_rate;
   logic [MSR_N_KIND-1:0] flag_set;
   logic [MSR_N_KIND-1:0] flag_clr;
   logic [MSR_N_KIND-1:0] sample_flag;
   logic temp_sample_ready;
   logic rate_sample_ready;
   logic accel_sample_ready;
   logic [MSR_WORD_W-1:0] word_view [MSR_N_WORD];
   logic [7:0] lo_addr [MSR_N_WORD];
   logic [7:0] hi_addr [MSR_N_WORD];
   logic [MSR_N_WORD-1:0] lo_hit;
   logic [MSR_N_WORD-1:0] hi_hit;
   logic [7:0] lo_byte [MSR_N_WORD];
   logic [7:0] hi_byte [MSR_N_WORD];
   logic status_hit;
   logic [7:0] status_byte;
   logic [7:0] rd_data_ff;
   logic [7:0] nxt_rd_data;
   logic rd_valid_ff;
   logic nxt_rd_valid;

   // ----------------------------------------
   // Sample capture
   // ----------------------------------------
   // The words are not latched between a low and a high byte read, so a sample
   // landing between the two reads mixes two samples. The host should poll the
   // status flag and fetch a word without long gaps.
   always_comb
   begin
      nxt_temp = temp_ff;
      nxt_rate = rate_ff;
      if (temp_valid_i)
      begin
         // Upstream delivers the word already sign-extended to bit 15.
         nxt_temp = temp_word_i;
      end
      if (rate_valid_i)
      begin
         nxt_rate = rate_set_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         temp_ff <= MSR_WORD_RST;
         rate_ff <= '{MSR_WORD_RST, MSR_WORD_RST, MSR_WORD_RST};
      end
      else
      begin
         temp_ff <= nxt_temp;
         rate_ff <= nxt_rate;
      end
   end

   // ----------------------------------------
   // Word table and address map
   // ----------------------------------------
   assign word_view[MSR_WORD_TEMP] = temp_ff;
   assign word_view[MSR_WORD_PITCH] = rate_ff.pitch;
   assign word_view[MSR_WORD_ROLL] = rate_ff.roll;
   assign word_view[MSR_WORD_YAW] = rate_ff.yaw;
   assign lo_addr[MSR_WORD_TEMP] = MSR_ADDR_TEMP_LO;
   assign hi_addr[MSR_WORD_TEMP] = MSR_ADDR_TEMP_HI;
   assign lo_addr[MSR_WORD_PITCH] = MSR_ADDR_PITCH_LO;
   assign hi_addr[MSR_WORD_PITCH] = MSR_ADDR_PITCH_HI;
   assign lo_addr[MSR_WORD_ROLL] = MSR_ADDR_ROLL_LO;
   assign hi_addr[MSR_WORD_ROLL] = MSR_ADDR_ROLL_HI;
   assign lo_addr[MSR_WORD_YAW] = MSR_ADDR_YAW_LO;
   assign hi_addr[MSR_WORD_YAW] = MSR_ADDR_YAW_HI;

   generate
      for (genvar w = 0; w < MSR_N_WORD; w++)
      begin : g_word
         // The low byte holds bits 7:0 and the high byte bits 15:8 of each word.
         assign lo_byte[w] = word_view[w][MSR_BYTE_W-1:0];
         assign hi_byte[w] = word_view[w][MSR_WORD_W-1:MSR_BYTE_W];
         assign lo_hit[w] = rd_req_i.rd_en && (rd_req_i.addr == lo_addr[w]);
         assign hi_hit[w] = rd_req_i.rd_en && (rd_req_i.addr == hi_addr[w]);
      end
   endgenerate

   assign status_hit = rd_req_i.rd_en && (rd_req_i.addr == MSR_ADDR_STATUS);

   // ----------------------------------------
   // New-sample flags
   // ----------------------------------------
   // The temperature and rate flags clear on the read of the high byte of their last word, so a host
   // reading low then high consumes the whole sample exactly once. Reading the
   // status byte leaves the flags alone.
   assign flag_set[MSR_BIT_TEMP] = temp_valid_i;
   assign flag_set[MSR_BIT_RATE] = rate_valid_i;
   assign flag_set[MSR_BIT_ACCEL] = accel_valid_i;
   assign flag_clr[MSR_BIT_TEMP] = hi_hit[MSR_WORD_TEMP];
   assign flag_clr[MSR_BIT_RATE] = hi_hit[MSR_WORD_YAW];
   // The acceleration words live outside this slice, so their read arrives as a strobe.
   assign flag_clr[MSR_BIT_ACCEL] = accel_read_i;

   generate
      for (genvar k = 0; k < MSR_N_KIND; k++)
      begin : g_flag
         logic flag_ff;
         logic nxt_flag;

         // A new sample wins over a same-cycle clearing read so no event is lost.
         always_comb
         begin
            nxt_flag = flag_set[k] | (flag_ff & ~flag_clr[k]);
         end

         always_ff @(posedge sys_clk_i)
         begin
            if (srst_i)
            begin
               flag_ff <= MSR_FLAG_RST;
            end
            else
            begin
               flag_ff <= nxt_flag;
            end
         end

         assign sample_flag[k] = flag_ff;
      end
   endgenerate

   assign temp_sample_ready = sample_flag[MSR_BIT_TEMP];
   assign rate_sample_ready = sample_flag[MSR_BIT_RATE];
   assign accel_sample_ready = sample_flag[MSR_BIT_ACCEL];

   always_comb
   begin
      status_byte = MSR_BYTE_ZERO;
      status_byte[MSR_BIT_TEMP] = temp_sample_ready;
      status_byte[MSR_BIT_RATE] = rate_sample_ready;
      status_byte[MSR_BIT_ACCEL] = accel_sample_ready;
   end

   // ----------------------------------------
   // Register read decode
   // ----------------------------------------
   // Unmapped addresses read as zero. The answer is registered so the data and
   // its valid strobe leave the block together one cycle after the request.
   always_comb
   begin
      nxt_rd_valid = rd_req_i.rd_en;
      nxt_rd_data = rd_data_ff;
      if (rd_req_i.rd_en)
      begin
         nxt_rd_data = MSR_BYTE_ZERO;
         if (status_hit)
         begin
            nxt_rd_data = status_byte;
         end
         for (int w = 0; w < MSR_N_WORD; w++)
         begin
            if (lo_hit[w])
            begin
               nxt_rd_data = lo_byte[w];
            end
            if (hi_hit[w])
            begin
               nxt_rd_data = hi_byte[w];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         rd_data_ff <= MSR_BYTE_ZERO;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   assign rd_data_o = rd_data_ff;
   assign rd_valid_o = rd_valid_ff;
   assign sample_ready_o = sample_flag;

endmodule

//--- dv/msr_host_model.sv
// Host side model that issues single register reads.
`timescale 1ns/100ps
module msr_host_model
(
   input wire logic sys_clk_i,
   output msr_pkg::msr_rd_req_t rd_req_o,
   input wire logic [7:0] rd_data_i,
   input wire logic rd_valid_i
);
   import msr_pkg::*;
   initial rd_req_o = '{rd_en: 1'b0, addr: 8'hff};
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      #1 rd_req_o = '{rd_en: 1'b1, addr: a};
      @(posedge sys_clk_i);
      #1 d = rd_valid_i ? rd_data_i : 8'hxx;
      // The address is scrambled once released so a stale value cannot pass.
      rd_req_o = '{rd_en: 1'b0, addr: ~a};
   endtask
endmodule

//--- dv/msr_readout_assertions.sv
// Checker for the sample readout port relations.
`timescale 1ns/100ps
module msr_readout_assertions
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic temp_valid_i,
   input wire logic [15:0] temp_word_i,
   input wire logic rate_valid_i,
   input wire msr_pkg::msr_rate_set_t rate_set_i,
   input wire logic accel_valid_i,
   input wire logic accel_read_i,
   input wire msr_pkg::msr_rd_req_t rd_req_i,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_valid_o,
   input wire logic [2:0] sample_ready_o
);
   import msr_pkg::*;
   logic [15:0] temp_shadow;
   logic [15:0] yaw_shadow;
   // Copies of the last delivered temperature and yaw words, to compare against what the host reads.
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         temp_shadow <= 16'h0000;
         yaw_shadow <= 16'h0000;
      end
      else
      begin
         if (temp_valid_i)
         begin
            temp_shadow <= temp_word_i;
         end
         if (rate_valid_i)
         begin
            yaw_shadow <= rate_set_i.yaw;
         end
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   a_read_answer: assert property (rd_req_i.rd_en |=> rd_valid_o) else $error("no read answer");
   a_status_top: assert property (rd_req_i.rd_en && rd_req_i.addr == MSR_ADDR_STATUS |=> rd_data_o[7:3] == 5'h00)
      else $error("status top bits set");
   a_status_flags: assert property (rd_req_i.rd_en && rd_req_i.addr == MSR_ADDR_STATUS
      |=> rd_data_o[2:0] == $past(sample_ready_o)) else $error("status flags differ");
   a_temp_flag: assert property (temp_valid_i |=> sample_ready_o[2]) else $error("temp flag");
   a_rate_flag: assert property (rate_valid_i |=> sample_ready_o[1]) else $error("rate flag");
   a_accel_flag: assert property (accel_valid_i |=> sample_ready_o[0]) else $error("accel flag");
   a_temp_high: assert property (rd_req_i.rd_en && rd_req_i.addr == MSR_ADDR_TEMP_HI
      |=> rd_data_o == $past(temp_shadow[15:8])) else $error("temp high byte");
   a_yaw_low: assert property (rd_req_i.rd_en && rd_req_i.addr == MSR_ADDR_YAW_LO
      |=> rd_data_o == $past(yaw_shadow[7:0])) else $error("yaw low byte");
   a_temp_clear: assert property (rd_req_i.rd_en && rd_req_i.addr == MSR_ADDR_TEMP_HI && !temp_valid_i
      |=> !sample_ready_o[2]) else $error("temp flag kept");
   a_accel_clear: assert property (accel_read_i && !accel_valid_i |=> !sample_ready_o[0])
      else $error("accel flag kept");
endmodule
bind msr_readout msr_readout_assertions u_chk(.sys_clk_i(sys_clk_i), .srst_i(srst_i), .temp_valid_i(temp_valid_i),
   .temp_word_i(temp_word_i), .rate_valid_i(rate_valid_i), .rate_set_i(rate_set_i), .accel_valid_i(accel_valid_i),
   .accel_read_i(accel_read_i), .rd_req_i(rd_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
   .sample_ready_o(sample_ready_o));

//--- dv/msr_readout_tb.sv
// Self-checking bench for the sample readout.
`timescale 1ns/100ps
module msr_readout_tb;
   import msr_pkg::*;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic tv = 1'b0, rv = 1'b0, av = 1'b0, ar = 1'b0;
   logic [63:0] v = 64'h7f01_c3e2_0b94_8a5c;
   logic [7:0] d;
   msr_rd_req_t req;
   logic [7:0] rdata;
   logic rvalid;
   logic [2:0] ready;
   int err_count = 0, n_checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   msr_readout u_dut(.sys_clk_i(sys_clk_i), .srst_i(srst_i), .temp_valid_i(tv), .temp_word_i(v[15:0]),
      .rate_valid_i(rv), .rate_set_i(v[63:16]), .accel_valid_i(av), .accel_read_i(ar), .rd_req_i(req),
      .rd_data_o(rdata), .rd_valid_o(rvalid), .sample_ready_o(ready));
   msr_host_model u_host(.sys_clk_i(sys_clk_i), .rd_req_o(req), .rd_data_i(rdata), .rd_valid_i(rvalid));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: read %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #20000 err_count++;
      end_sim();
   end
   initial
   begin
      repeat (4) @(posedge sys_clk_i);
      #1 srst_i = 1'b0;
      chk({5'h00, ready}, 8'h00);
      u_host.rd(MSR_ADDR_STATUS, d);
      chk(d, 8'h00);
      chk({7'h00, rvalid}, 8'h01);
      @(posedge sys_clk_i);
      #1 {tv, rv, av} = 3'h7;
      @(posedge sys_clk_i);
      #1 {tv, rv, av} = 3'h0;
      chk({5'h00, ready}, 8'h07);
      u_host.rd(MSR_ADDR_STATUS, d);
      chk(d, 8'h07);
      // Sign of the temperature word rides in bit 7 of the high byte.
      for (int i = 0; i < 8; i++)
      begin
         u_host.rd(MSR_ADDR_TEMP_LO + i[7:0], d);
         chk(d, v[8*i +: 8]);
      end
      u_host.rd(MSR_ADDR_STATUS, d);
      chk(d, 8'h01);
      @(posedge sys_clk_i);
      #1 ar = 1'b1;
      @(posedge sys_clk_i);
      #1 ar = 1'b0;
      chk({5'h00, ready}, 8'h00);
      u_host.rd(MSR_ADDR_STATUS, d);
      chk(d, 8'h00);
      u_host.rd(8'h30, d);
      chk(d, 8'h00);
      // A new temperature sample in the cycle of the clearing read keeps the flag.
      fork
         u_host.rd(MSR_ADDR_TEMP_HI, d);
         begin
            @(posedge sys_clk_i);
            #1 tv = 1'b1;
            @(posedge sys_clk_i);
            #1 tv = 1'b0;
         end
      join
      chk(d, v[15:8]);
      chk({5'h00, ready}, 8'h04);
      // Reset in mid-run drops the flags and the words.
      @(posedge sys_clk_i);
      #1 srst_i = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1 srst_i = 1'b0;
      chk({5'h00, ready}, 8'h00);
      u_host.rd(MSR_ADDR_TEMP_HI, d);
      chk(d, 8'h00);
      end_sim();
   end
endmodule
